// [dvc_pkg.sv]
// Constants and types for the display value conversion datapath.
// Assumes currents in microamps, scale values as signed integers.
package dvc_pkg;
    // --------------------------------------------------
    // Fixed point and input ranges
    // --------------------------------------------------
    localparam int FRAC = 16;  // Fraction bits of the normalized value.
    localparam logic [31:0] CUR_LO_UA = 32'h0000_0FA0;  // 4 mA.
    localparam logic [31:0] CUR_FS_UA = 32'h0000_4E20;  // 20 mA.
    localparam logic [31:0] SPAN_4_20 = 32'h0000_3E80;  // 16 mA.
    localparam logic [31:0] PERMILLE = 32'h0000_03E8;   // 1000.
    localparam logic [31:0] PI_4_Q16 = 32'h0000_C910;   // pi/4.
    localparam logic [31:0] THREE_Q16 = 32'h0003_0000;  // 3.0.
    localparam int MAX_POINTS = 20;
    localparam logic [4:0] MIN_POINTS = 5'h02;
    localparam int LATENCY = 3;  // Sample strobe to result strobe.
    // --------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOW = 8'h04;
    localparam logic [7:0] OFS_HIGH = 8'h08;
    localparam logic [7:0] OFS_MARGIN = 8'h0C;
    localparam logic [7:0] OFS_TOFF = 8'h10;
    localparam logic [7:0] OFS_TSPAN = 8'h14;
    localparam logic [7:0] OFS_H1 = 8'h18;
    localparam logic [7:0] OFS_H2 = 8'h1C;
    localparam logic [7:0] OFS_H3 = 8'h20;
    localparam logic [7:0] OFS_DIAM = 8'h24;
    localparam logic [7:0] OFS_NPTS = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;
    localparam logic [7:0] OFS_PTS = 8'h40;  // Point i at 0x40 + 4*i.
    // Field positions.
    localparam int CTRL_RANGE_BIT = 0;  // 1 selects the 4-20 mode.
    localparam int CTRL_CHAR_LSB = 1;   // Characteristic, 3 bits.
    localparam int MARGIN_HI_LSB = 16;  // Upper margin field.
    // Characteristic codes, in order 0 to 5.
    typedef enum logic [2:0] {
        CH_LINEAR, CH_SQUARE, CH_SQRT, CH_USER, CH_TANK_V, CH_TANK_H
    } dvc_char_e;
    // One converted result with its strobe and range alarm.
    typedef struct packed {
        logic valid;
        logic alarm;
        logic [31:0] value;
    } dvc_result_s;
endpackage

// [dvc_conv.sv]
// Display value conversion datapath with an AHB-Lite register slave.
// Assumes one clock, samples synchronous to hclk, single word access.
//
// What this block does
// - Linear: n times span plus low value.
// - Low above high gives a falling result.
// - Square: square n, then linear scaling.
// - Square root: root n, then linear scaling.
// - Root of negative n gives low value.
// - User curve holds 2 to 20 points.
// - Bracketing segment interpolates the user curve.
// - Outside the curve, extend outermost segment.
// - Tank level is n times span plus offset.
// - Tank volume integrates area over level.
// - 4-20 window widened by margins in 0.1 percent.
// - 4-20 mode: subtract 4 mA, divide by 16.
// - 0-20 mode: divide by 20 mA only.
// - Characteristic codes 0 to 5 in order.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module dvc_conv import dvc_pkg::*; #(
    parameter int NPTS = MAX_POINTS
) (
    // Clock, reset and enable.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Sample input from the front end.
    input wire logic in_valid,
    input wire logic [15:0] in_current_ua,
    // Result to the display path.
    output dvc_result_s out_result
);
    // --------------------------------------------------
    // Helpers
    // --------------------------------------------------
    // Q16 product, cut back to 32 bits.
    function automatic logic signed [31:0] mulq(
        input logic signed [31:0] a, input logic signed [31:0] b);
        logic signed [63:0] p;
        p = a * b;
        return p[47:16];
    endfunction
    // Bitwise integer square root of a 34-bit radicand.
    function automatic logic [16:0] isqrt(input logic [33:0] v);
        logic [33:0] rem;
        logic [16:0] root;
        logic [33:0] trial;
        rem = v;
        root = '0;
        for (int i = 16; i >= 0; i--) begin
            trial = (({17'h0_0000, root} << (i + 1)) | (34'h1 << (2 * i)));
            if (rem >= trial) begin
                rem = rem - trial;
                root[i] = 1'b1;
            end
        end
        return root;
    endfunction
    // --------------------------------------------------
    // Registers
    // --------------------------------------------------
    logic [3:0] ctrl_q;  // Range bit and characteristic code.
    logic signed [31:0] low_scale_value_q;
    logic signed [31:0] high_scale_value_q;
    logic [9:0] lower_range_margin_q;  // In 0.1 percent.
    logic [9:0] upper_range_margin_q;
    logic signed [31:0] tank_level_offset_q;
    logic signed [31:0] tank_level_span_q;
    logic signed [31:0] tank_first_height_q;  // Dead part below.
    logic signed [31:0] tank_second_height_q; // Body height or length.
    logic signed [31:0] tank_third_height_q;  // Stored for software.
    logic signed [31:0] tank_diameter_q;
    logic [4:0] npts_q;
    logic [15:0] pt_x_q [NPTS];  // X in 0.1 percent.
    logic signed [15:0] pt_y_q [NPTS];
    logic wr_pend_q;  // A write data phase is due.
    logic [7:0] wr_addr_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    dvc_char_e mode;
    logic range_420;
    assign mode = dvc_char_e'(ctrl_q[CTRL_CHAR_LSB +: 3]);
    assign range_420 = ctrl_q[CTRL_RANGE_BIT];
    // --------------------------------------------------
    // Bus slave
    // --------------------------------------------------
    logic addr_ph;  // Valid address phase this cycle.
    assign addr_ph = hsel & htrans[1] & hready;
    // The slave never stalls; writes land in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hreadyout_q <= 1'b1;
        end else if (ce) begin
            wr_pend_q <= addr_ph & hwrite;
            wr_addr_q <= haddr[7:0];
            hreadyout_q <= 1'b1;
        end
    end
    // Read data are fetched in the address phase; unmapped reads zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (ce && addr_ph && !hwrite) begin
            hrdata_q <= 32'h0000_0000;
            case (haddr[7:0])
                OFS_CTRL: hrdata_q <= {28'h000_0000, ctrl_q};
                OFS_LOW: hrdata_q <= low_scale_value_q;
                OFS_HIGH: hrdata_q <= high_scale_value_q;
                OFS_MARGIN: hrdata_q <= {6'h00, upper_range_margin_q,
                                         6'h00, lower_range_margin_q};
                OFS_TOFF: hrdata_q <= tank_level_offset_q;
                OFS_TSPAN: hrdata_q <= tank_level_span_q;
                OFS_H1: hrdata_q <= tank_first_height_q;
                OFS_H2: hrdata_q <= tank_second_height_q;
                OFS_H3: hrdata_q <= tank_third_height_q;
                OFS_DIAM: hrdata_q <= tank_diameter_q;
                OFS_NPTS: hrdata_q <= {27'h000_0000, npts_q};
                OFS_STATUS: hrdata_q <= out_result.value;
                default: begin
                    for (int i = 0; i < NPTS; i++) begin
                        if (haddr[7:0] == OFS_PTS + 8'(4 * i)) begin
                            hrdata_q <= {pt_y_q[i], pt_x_q[i]};
                        end
                    end
                end
            endcase
        end
    end
    // Configuration writes; the point count is clamped into range.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= 4'h0;
            low_scale_value_q <= 32'h0000_0000;
            high_scale_value_q <= 32'h0000_0000;
            lower_range_margin_q <= 10'h000;
            upper_range_margin_q <= 10'h000;
            tank_level_offset_q <= 32'h0000_0000;
            tank_level_span_q <= 32'h0000_0000;
            tank_first_height_q <= 32'h0000_0000;
            tank_second_height_q <= 32'h0000_0000;
            tank_third_height_q <= 32'h0000_0000;
            tank_diameter_q <= 32'h0000_0000;
            npts_q <= MIN_POINTS;
            for (int i = 0; i < NPTS; i++) begin
                pt_x_q[i] <= 16'h0000;
                pt_y_q[i] <= 16'h0000;
            end
        end else if (ce && wr_pend_q) begin
            case (wr_addr_q)
                // Codes above 5 give the low scale value.
                OFS_CTRL: ctrl_q <= hwdata[3:0];
                OFS_LOW: low_scale_value_q <= hwdata;
                OFS_HIGH: high_scale_value_q <= hwdata;
                OFS_MARGIN: begin
                    lower_range_margin_q <= hwdata[9:0];
                    upper_range_margin_q <= hwdata[MARGIN_HI_LSB +: 10];
                end
                OFS_TOFF: tank_level_offset_q <= hwdata;
                OFS_TSPAN: tank_level_span_q <= hwdata;
                OFS_H1: tank_first_height_q <= hwdata;
                OFS_H2: tank_second_height_q <= hwdata;
                OFS_H3: tank_third_height_q <= hwdata;
                OFS_DIAM: tank_diameter_q <= hwdata;
                OFS_NPTS: begin
                    if (hwdata[4:0] < MIN_POINTS) begin
                        npts_q <= MIN_POINTS;
                    end else if (hwdata[4:0] > 5'(NPTS)) begin
                        npts_q <= 5'(NPTS);
                    end else begin
                        npts_q <= hwdata[4:0];
                    end
                end
                default: begin
                    for (int i = 0; i < NPTS; i++) begin
                        if (wr_addr_q == OFS_PTS + 8'(4 * i)) begin
                            pt_x_q[i] <= hwdata[15:0];
                            pt_y_q[i] <= hwdata[31:16];
                        end
                    end
                end
            endcase
        end
    end
    // --------------------------------------------------
    // Stage 1: normalize and check the window
    // --------------------------------------------------
    logic s1_v_q, s1_al_q;
    logic signed [31:0] s1_n_q;  // Normalized value, Q16.
    always_ff @(posedge hclk or negedge hresetn) begin
        logic signed [47:0] num;
        logic [31:0] cur, lo_lim, hi_lim;
        num = '0;
        cur = '0;
        lo_lim = '0;
        hi_lim = '0;
        if (!hresetn) begin
            s1_v_q <= 1'b0;
            s1_al_q <= 1'b0;
            s1_n_q <= 32'h0000_0000;
        end else if (ce) begin
            s1_v_q <= in_valid;
            cur = {16'h0000, in_current_ua};
            hi_lim = CUR_FS_UA + CUR_FS_UA * 32'(upper_range_margin_q)
                     / PERMILLE;
            if (range_420) begin
                lo_lim = CUR_LO_UA - CUR_LO_UA * 32'(lower_range_margin_q)
                         / PERMILLE;
                num = (48'(cur) - 48'(CUR_LO_UA)) <<< FRAC;
                s1_n_q <= 32'(num / $signed(48'(SPAN_4_20)));
            end else begin
                num = 48'(cur) <<< FRAC;
                s1_n_q <= 32'(num / 48'(CUR_FS_UA));
            end
            s1_al_q <= (cur < lo_lim) || (cur > hi_lim);
        end
    end
    // --------------------------------------------------
    // Stage 2: shape, pick a segment, find the level
    // --------------------------------------------------
    logic s2_v_q, s2_al_q;
    logic signed [31:0] s2_n_q, s2_f_q, s2_lvl_q;
    logic signed [31:0] s2_xl_q, s2_dx_q, s2_yl_q, s2_dy_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        int seg;
        seg = 0;
        if (!hresetn) begin
            s2_v_q <= 1'b0;
            s2_al_q <= 1'b0;
            s2_n_q <= 32'h0000_0000;
            s2_f_q <= 32'h0000_0000;
            s2_lvl_q <= 32'h0000_0000;
            s2_xl_q <= 32'h0000_0000;
            s2_dx_q <= 32'h0000_0000;
            s2_yl_q <= 32'h0000_0000;
            s2_dy_q <= 32'h0000_0000;
        end else if (ce) begin
            s2_v_q <= s1_v_q;
            s2_al_q <= s1_al_q;
            s2_n_q <= s1_n_q;
            case (mode)
                CH_SQUARE: s2_f_q <= mulq(s1_n_q, s1_n_q);
                CH_SQRT: begin
                    if (s1_n_q < 0) begin
                        s2_f_q <= 32'h0000_0000;
                    end else begin
                        s2_f_q <= 32'(isqrt({s1_n_q[31:0], 2'b00} << 14));
                    end
                end
                default: s2_f_q <= s1_n_q;
            endcase
            // Last segment whose low X is not above n; the end segments
            // stretch outward on both sides.
            for (int i = 1; i < NPTS - 1; i++) begin
                if (i < int'(npts_q) - 1 && 64'(s1_n_q) * $signed(64'(PERMILLE))
                    >= $signed(64'(pt_x_q[i]) <<< FRAC)) begin
                    seg = i;
                end
            end
            s2_xl_q <= 32'(pt_x_q[seg]);
            s2_dx_q <= 32'(pt_x_q[seg + 1]) - 32'(pt_x_q[seg]);
            s2_yl_q <= 32'(pt_y_q[seg]);
            s2_dy_q <= 32'(pt_y_q[seg + 1]) - 32'(pt_y_q[seg]);
            s2_lvl_q <= mulq(s1_n_q, tank_level_span_q)
                        + tank_level_offset_q;
        end
    end
    // --------------------------------------------------
    // Stage 3: final value
    // --------------------------------------------------
    logic signed [31:0] area, hef, tq;
    logic signed [63:0] unum;
    // Area of the cross section and the wetted height.
    always_comb begin
        area = mulq(mulq(tank_diameter_q <<< FRAC, tank_diameter_q),
                    PI_4_Q16);
        hef = s2_lvl_q - tank_first_height_q;
        if (hef < 0) begin
            hef = 32'h0000_0000;
        end
        unum = (64'(s2_n_q) * 64'(PERMILLE) - (64'(s2_xl_q) <<< FRAC))
               * 64'(s2_dy_q);
        tq = 32'h0000_0000;
        if (tank_diameter_q > 0) begin
            tq = (hef >= tank_diameter_q) ? (32'sd1 <<< FRAC)
                 : 32'((64'(hef) <<< FRAC) / 64'(tank_diameter_q));
        end
    end
    dvc_result_s res_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_q <= '0;
        end else if (ce) begin
            res_q.valid <= s2_v_q;
            if (s2_v_q) begin  // Value and alarm hold between strobes.
                res_q.alarm <= s2_al_q;
                case (mode)
                    CH_LINEAR, CH_SQUARE, CH_SQRT: begin
                        res_q.value <= mulq(s2_f_q, high_scale_value_q
                            - low_scale_value_q) + low_scale_value_q;
                    end
                    CH_USER: begin
                        if (s2_dx_q == 0) begin
                            res_q.value <= s2_yl_q;
                        end else begin
                            res_q.value <= 32'(unum / (64'(s2_dx_q) <<< FRAC))
                                           + s2_yl_q;
                        end
                    end
                    CH_TANK_V: begin
                        // Upright: area times height, capped at the body.
                        res_q.value <= area * ((hef > tank_second_height_q)
                            ? tank_second_height_q : hef);
                    end
                    CH_TANK_H: begin
                        // Lying: segment fraction approximated by t*t*(3-2t),
                        // within four percent of the exact circle.
                        res_q.value <= mulq(area * tank_second_height_q,
                            mulq(mulq(tq, tq), THREE_Q16 - (tq <<< 1)));
                    end
                    default: res_q.value <= low_scale_value_q;
                endcase
            end
        end
    end
    // --------------------------------------------------
    // Outputs
    // --------------------------------------------------
    assign out_result = res_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
endmodule

// [dvc_conv_chk.sv]
// Port checker for the display value conversion block.
// Assumes ce is held high by the bench except during the frozen results check.
`timescale 1ns/1ps
module dvc_conv_chk import dvc_pkg::*; (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Register bus.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Sample path.
    input wire logic in_valid,
    input wire dvc_result_s out_result
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // A read address phase that the slave takes at this edge.
    logic rd_take;
    assign rd_take = hsel && htrans[1] && hready && ce && !hwrite;
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not OKAY");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    a_result_latency: assert property (in_valid && ce |-> ##3 out_result.valid)
        else $error("result strobe late or missing");
    a_valid_cause: assert property (out_result.valid |-> $past(in_valid, 3))
        else $error("result strobe without a sample");
    // Value and alarm may only move with the strobe, so the display never tears.
    a_result_hold: assert property (!out_result.valid |->
        $stable(out_result.value) && $stable(out_result.alarm))
        else $error("result moved without strobe");
    a_unmapped_zero: assert property (rd_take && haddr[7:4] == 4'h3 |=>
        hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_npts_range: assert property (rd_take && haddr[7:0] == OFS_NPTS |=>
        hrdata >= 32'h0000_0002 && hrdata <= 32'h0000_0014)
        else $error("point count out of range");
    a_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
        else $error("read data moved without a read");
    c_result: cover property (out_result.valid && !out_result.alarm);
    c_alarm: cover property (out_result.valid && out_result.alarm);
    c_unmapped: cover property (rd_take && haddr[7:4] == 4'h3);
endmodule

// [dvc_front.sv]
// Front end model: sends current samples and collects the results.
// Assumes the bench calls send and drains the got queue.
`timescale 1ns/1ps
module dvc_front import dvc_pkg::*; (
    // Clock.
    input wire logic hclk,
    // Sample output and result input.
    output logic in_valid,
    output logic [15:0] in_current_ua,
    input wire dvc_result_s out_result
);
    logic [32:0] got[$];  // Alarm and value of each result.
    initial begin
        in_valid = 1'b0;
        in_current_ua = 16'h0000;
    end
    // One-cycle strobe; the current is scrambled after it so stale data shows.
    task automatic send(input logic [15:0] cur);
        @(posedge hclk);
        in_valid <= 1'b1;
        in_current_ua <= cur;
        @(posedge hclk);
        in_valid <= 1'b0;
        in_current_ua <= ~cur;
    endtask
    // Capture every strobed result.
    always @(posedge hclk) begin
        if (out_result.valid) begin
            got.push_back({out_result.alarm, out_result.value});
        end
    end
endmodule

// [tb.sv]
// Self-checking bench for the conversion block with a reference model.
// Assumes dvc_front.sv and dvc_conv_chk.sv are compiled first.
`timescale 1ns/1ps
module tb;
    import dvc_pkg::*;
    logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, in_valid;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] in_current_ua;
    dvc_result_s out_result;
    int failures = 0, samples_checked = 0;
    int mode, ch, tol, np;  // Model state shadowing the registers.
    longint lo, hi, lom, him;
    longint px[4] = '{0, 300, 400, 1000}, py[4] = '{-50, 30, 80, 900};
    longint toff = 5, tspan = 100, th1 = 20, th2 = 50, tdia = 40;  // Tank shape.
    dvc_conv DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid),
        .in_current_ua(in_current_ua), .out_result(out_result));
    dvc_front fe (.hclk(hclk), .in_valid(in_valid), .in_current_ua(in_current_ua),
        .out_result(out_result));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ----------------------------------------
    // Bus tasks, comparison and model
    // ----------------------------------------
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    // An unknown bit makes the range test unknown, which counts as a mismatch.
    task automatic chk(input string nm, input longint e, input logic signed [31:0] g,
        input int t);
        samples_checked++;
        if ((g >= e - t && g <= e + t) !== 1'b1) begin
            failures++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input longint e);
        xfer(a, 1'b0, 32'h0000_0000);
        chk("register", e, hrdata, 0);
    endtask
    function automatic longint lin(input longint x);
        return ((x * (hi - lo)) >>> 16) + lo;
    endfunction
    // Tolerance of two counts covers the unstated rounding of root and division.
    function automatic longint model(input int cur);
        longint n, lvl, ar, t;
        int i;
        n = mode ? ((cur - 4000) * 64'sd65536) / 16000 : (cur * 64'sd65536) / 20000;
        tol = 2;
        case (ch)
            0: return lin(n);
            1: return lin((n * n) >>> 16);
            2: begin
                if (n < 0) begin
                    tol = 0;
                    return lo;
                end
                return lin($rtoi($sqrt(n * 65536.0)));
            end
            3: begin
                i = 0;
                while (i < np - 2 && n * 1000 >= px[i + 1] * 65536) i++;
                return py[i] + ((n * 1000 - px[i] * 65536) * (py[i + 1] - py[i]))
                    / ((px[i + 1] - px[i]) * 65536);
            end
            4, 5: begin
                lvl = ((n * tspan) >>> 16) + toff;
                lvl = (lvl > th1) ? lvl - th1 : 0;
                ar = (tdia * tdia * longint'(PI_4_Q16)) >>> 16;
                if (ch == 4) return ar * ((lvl > th2) ? th2 : lvl);
                t = (lvl >= tdia) ? 65536 : (lvl * 65536) / tdia;
                return (ar * th2 * ((((t * t) >>> 16) * (196608 - 2 * t)) >>> 16)) >>> 16;
            end
            default: return lo;
        endcase
    endfunction
    task automatic run(input int cur);
        logic [32:0] r;
        longint e;
        int w;
        fe.send(cur[15:0]);
        w = 0;
        while (fe.got.size() == 0 && w < 20) begin
            @(posedge hclk);
            w++;
        end
        e = model(cur);
        r = (fe.got.size() > 0) ? fe.got.pop_front() : 33'bx;
        chk("value", e, r[31:0], tol);
        e = (cur < (mode ? 4000 - 4 * lom : 0) || cur > 20000 + 20 * him) ? 1 : 0;
        chk("alarm", e, {31'h0000_0000, r[32]}, 0);
    endtask
    task automatic results();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog, far beyond the roughly eight hundred cycles the run needs.
    initial begin
        repeat (50000) @(posedge hclk);
        failures++;
        $display("[FAIL] watchdog expected done seen timeout");
        results();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        void'($urandom(32'h9afb649e));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(OFS_CTRL, 0);
        rdchk(OFS_NPTS, 2);
        wr(8'h30, 32'h1234_5678);
        rdchk(8'h30, 0);
        wr(OFS_NPTS, 32'h0000_0001);
        rdchk(OFS_NPTS, 2);
        wr(OFS_NPTS, 32'h0000_0019);
        rdchk(OFS_NPTS, 20);
        // With the enable low a sample must leave no result behind.
        ce <= 1'b0;
        fe.send(16'h1F40);
        repeat (6) @(posedge hclk);
        chk("frozen results", 0, fe.got.size(), 0);
        ce <= 1'b1;
        $display("test registers done");
        lom = 200;
        him = 110;
        wr(OFS_MARGIN, {6'h00, 10'(him), 6'h00, 10'(lom)});
        for (int i = 0; i < 4; i++) wr(OFS_PTS + 8'(4 * i), {py[i][15:0], px[i][15:0]});
        np = 4;
        wr(OFS_NPTS, 32'h0000_0004);
        wr(OFS_TOFF, 32'(toff));
        wr(OFS_TSPAN, 32'(tspan));
        wr(OFS_H1, 32'(th1));
        wr(OFS_H2, 32'(th2));
        wr(OFS_DIAM, 32'(tdia));
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 8; c++) begin
                lo = int'($urandom_range(0, 10998)) - 999;
                hi = int'($urandom_range(0, 10998)) - 999;
                wr(OFS_LOW, 32'(lo));
                wr(OFS_HIGH, 32'(hi));
                mode = m;
                ch = c;
                wr(OFS_CTRL, {28'h000_0000, 3'(c), 1'(m)});
                for (int k = 0; k < 6; k++) begin
                    run(m ? 2500 + 250 * int'($urandom_range(0, 79))
                        : 625 * int'($urandom_range(0, 36)));
                end
                $display("test mode %0d code %0d done", m, c);
            end
        end
        results();
    end
endmodule
bind dvc_conv dvc_conv_chk u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid),
    .out_result(out_result));
